//--- rtl/timer_h_pkg.sv
package timer_h_pkg;

  // Register byte offsets
  localparam logic [2:0] ADDR_MODE    = 3'h0;
  localparam logic [2:0] ADDR_CMP_A   = 3'h1;
  localparam logic [2:0] ADDR_CMP_B   = 3'h2;
  localparam logic [2:0] ADDR_CARRIER = 3'h3;
  localparam logic [2:0] ADDR_COUNT   = 3'h4;

  // Mode register fields, high bits first
  typedef struct packed {
    logic polarity;
    logic carrier_mode;
    logic run;
  } mode_t;

  localparam int unsigned MODE_W = 3;

  // Carrier control register fields, high bits first
  typedef struct packed {
    logic remote;
    logic master;
    logic slave;
  } carrier_ctl_t;

  localparam int unsigned CARRIER_W = 3;

  // Reset values
  localparam logic [2:0] MODE_RESET    = 3'h0;
  localparam logic [2:0] CARRIER_RESET = 3'h0;
  localparam logic [7:0] CMP_RESET     = 8'h00;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] RDATA_RESET   = 8'h00;

  // Clocks needed between a duty write and its transfer
  localparam int unsigned XFER_CLOCKS = 3;
  localparam logic [1:0]  XFER_AGE    = 2'(XFER_CLOCKS - 1);
  localparam logic [1:0]  AGE_MAX     = 2'h3;

  // Comparison phase of the counter
  typedef enum logic [1:0] {
    ST_STOP,
    ST_SKIP,
    ST_CMP_A,
    ST_CMP_B
  } phase_t;

endpackage : timer_h_pkg

//--- rtl/timer_h_pwm_carrier_gen.sv
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - On enable in PWM mode, skip one clock; output stays inactive meanwhile.
// - Running duty writes go to a latch, loaded at match with old duty.
// - Latched duty loads only if three clocks passed since the write.
// - Period match clears counter, drives output active, pulses match interrupt.
// - Duty match drives output inactive; no counter clear, no interrupt.
// - Clearing enable forces interrupt and output inactive; in carrier mode with remote clear the pin keeps following slave.
// - Carrier mode exists only on unit 1, driven on its output pin.
// - First compare sets carrier low width, second sets high width.
// - Remote and enable select low, high, low or carrier on the pin.
// - Carrier enable is master (read/write) and slave (read-only, gates).
// - Companion interrupt is synchronised; its pulse copies master to slave.
// - The copy happens on the fifth clock after the companion interrupt rises.
// - Carrier compares low width first; match pulses irq, clears, switches.
// - High width match pulses irq, clears, switches back, repeating forever.
// - Carrier reaches the pin only while the gate is high; the gate copies slave enable only while the wave is low.
// - Carrier period is N+M+2 clocks, high part M+1 clocks.
// - Clearing unit 1 enable stops carrier counting.
// - PWM period is N+1 clocks, active width M+1 clocks.
module timer_h_pwm_carrier_gen #(
  parameter bit CARRIER_CAPABLE = 1'b1
) (
  input  wire logic       MCLK,
  input  wire logic       RST,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       COMPANION_IRQ,
  output logic            TIMER_OUT,
  output logic            MATCH_IRQ
);

  timer_h_pkg::mode_t        mode;
  timer_h_pkg::carrier_ctl_t carrier;
  timer_h_pkg::phase_t       phase;
  timer_h_pkg::phase_t       next_phase;

  logic [7:0] period_compare;
  logic [7:0] duty_latch;
  logic [7:0] duty_compare;
  logic       duty_pending;
  logic [1:0] duty_age;
  logic [7:0] count;
  logic [7:0] next_count;
  logic       wave;
  logic       next_wave;
  logic       gate;
  logic       next_out;
  logic       next_irq;
  logic [2:0] irq_sync;
  logic       synced_companion_irq;
  logic       copy_strobe;
  logic [7:0] rd_value;

  // Register decode
  wire wr_mode    = WR && (ADDR == timer_h_pkg::ADDR_MODE);
  wire wr_cmp_a   = WR && (ADDR == timer_h_pkg::ADDR_CMP_A);
  wire wr_cmp_b   = WR && (ADDR == timer_h_pkg::ADDR_CMP_B);
  wire wr_carrier = WR && (ADDR == timer_h_pkg::ADDR_CARRIER);

  wire carrier_on = CARRIER_CAPABLE && mode.carrier_mode;
  wire counting   = (phase == timer_h_pkg::ST_CMP_A) || (phase == timer_h_pkg::ST_CMP_B);
  wire in_b       = (phase == timer_h_pkg::ST_CMP_B);

  // Active compare value depends on phase
  wire [7:0] cmp_now = in_b ? duty_compare : period_compare;
  wire       hit     = counting && (count == cmp_now);
  wire       hit_a   = hit && !in_b;
  wire       hit_b   = hit && in_b;

  // Latched duty may transfer only after enough clocks
  wire xfer_ok = duty_pending && (duty_age >= timer_h_pkg::XFER_AGE);
  wire do_xfer = hit_b && xfer_ok && !wr_cmp_b;

  // Counter clear: first compare always, second only in carrier mode
  wire clear_cnt = hit_a || (hit_b && carrier_on);

  // Phase sequencing
  always_comb begin
    next_phase = phase;
    if (!mode.run) begin
      next_phase = timer_h_pkg::ST_STOP;
    end else begin
      unique case (phase)
        timer_h_pkg::ST_STOP:  next_phase = timer_h_pkg::ST_SKIP;
        timer_h_pkg::ST_SKIP:  next_phase = timer_h_pkg::ST_CMP_A;
        timer_h_pkg::ST_CMP_A: next_phase = hit ? timer_h_pkg::ST_CMP_B : timer_h_pkg::ST_CMP_A;
        timer_h_pkg::ST_CMP_B: next_phase = hit ? timer_h_pkg::ST_CMP_A : timer_h_pkg::ST_CMP_B;
      endcase
    end
  end

  // Counter held at zero while stopped and through the skipped clock
  assign next_count = (!mode.run || !counting) ? timer_h_pkg::COUNT_RESET :
                      clear_cnt ? timer_h_pkg::COUNT_RESET :
                      8'(count + 8'h01);

  // Wave goes active on first compare, inactive on second
  assign next_wave = !mode.run ? 1'b0 :
                     hit_a     ? 1'b1 :
                     hit_b     ? 1'b0 :
                     wave;

  // Match interrupt pulse
  assign next_irq = mode.run && (hit_a || (hit_b && carrier_on));

  // Pin selection
  // Pin follows next_wave so it moves on the same edge as the match interrupt
  wire carrier_pin = carrier.remote ? (gate && next_wave) : carrier.slave;
  assign next_out  = carrier_on ? carrier_pin : (mode.polarity ^ next_wave);

  // Companion interrupt rise after synchronisation
  wire companion_rise = irq_sync[1] && !irq_sync[2];

  // Read data selection
  assign rd_value = (ADDR == timer_h_pkg::ADDR_MODE)    ? {5'h00, mode} :
                    (ADDR == timer_h_pkg::ADDR_CMP_A)   ? period_compare :
                    (ADDR == timer_h_pkg::ADDR_CMP_B)   ? duty_latch :
                    (ADDR == timer_h_pkg::ADDR_CARRIER) ? {5'h00, carrier} :
                    (ADDR == timer_h_pkg::ADDR_COUNT)   ? count :
                    8'h00;

  // Mode register
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      mode <= timer_h_pkg::MODE_RESET;
    end else if (wr_mode) begin
      mode <= timer_h_pkg::mode_t'(WDATA[timer_h_pkg::MODE_W-1:0]);
    end
  end

  // First compare register
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      period_compare <= timer_h_pkg::CMP_RESET;
    end else if (wr_cmp_a) begin
      period_compare <= WDATA;
    end
  end

  // Second compare: direct while stopped, latched while running
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      duty_latch   <= timer_h_pkg::CMP_RESET;
      duty_compare <= timer_h_pkg::CMP_RESET;
      duty_pending <= 1'b0;
    end else if (wr_cmp_b) begin
      duty_latch   <= WDATA;
      duty_pending <= mode.run;
      if (!mode.run) begin
        duty_compare <= WDATA;
      end
    end else if (do_xfer) begin
      duty_compare <= duty_latch;
      duty_pending <= 1'b0;
    end
  end

  // Clocks since the last second-compare write
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      duty_age <= 2'h0;
    end else if (wr_cmp_b) begin
      duty_age <= 2'h0;
    end else if (duty_age != timer_h_pkg::AGE_MAX) begin
      duty_age <= 2'(duty_age + 2'h1);
    end
  end

  // Counter, phase and wave
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      phase <= timer_h_pkg::ST_STOP;
      count <= timer_h_pkg::COUNT_RESET;
      wave  <= 1'b0;
    end else begin
      phase <= next_phase;
      count <= next_count;
      wave  <= next_wave;
    end
  end

  // Carrier gate changes only while the wave is low
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      gate <= 1'b0;
    end else if (!next_wave) begin
      gate <= carrier.slave;
    end
  end

  // Companion interrupt synchroniser and edge
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      irq_sync             <= 3'h0;
      synced_companion_irq <= 1'b0;
      copy_strobe          <= 1'b0;
    end else begin
      irq_sync             <= {irq_sync[1:0], COMPANION_IRQ};
      synced_companion_irq <= companion_rise;
      copy_strobe          <= synced_companion_irq;
    end
  end

  // Carrier control: master and remote writable, slave by copy only
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      carrier <= timer_h_pkg::CARRIER_RESET;
    end else begin
      if (wr_carrier) begin
        carrier.remote <= WDATA[2];
        carrier.master <= WDATA[1];
      end
      if (copy_strobe) begin
        carrier.slave <= carrier.master;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      TIMER_OUT <= 1'b0;
      MATCH_IRQ <= 1'b0;
      RDATA     <= timer_h_pkg::RDATA_RESET;
    end else begin
      TIMER_OUT <= next_out;
      MATCH_IRQ <= next_irq;
      RDATA     <= RD ? rd_value : timer_h_pkg::RDATA_RESET;
    end
  end

endmodule : timer_h_pwm_carrier_gen

`default_nettype wire

//--- sim/companion_timer_model.sv
`timescale 1ns/10ps
`default_nettype none
module companion_timer_model #(
  parameter int unsigned DIV = 8
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic start,
  output logic      irq
);
  logic [3:0] left;
  // Request spans one slow count clock
  assign irq = left != 4'h0;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      left <= 4'h0;
    end else begin
      left <= start ? 4'(DIV) : left - {3'h0, left != 4'h0};
    end
  end
endmodule : companion_timer_model
`default_nettype wire

//--- sim/timer_h_pwm_carrier_gen_props.sv
`timescale 1ns/10ps
`default_nettype none
module timer_h_pwm_carrier_gen_props (
  input wire logic       MCLK,
  input wire logic       RST,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       COMPANION_IRQ,
  input wire logic       TIMER_OUT,
  input wire logic       MATCH_IRQ
);
  logic [2:0] mode;
  logic [7:0] per;
  logic [7:0] gap;
  logic [1:0] quiet;
  logic       seen;
  logic       rem;
  wire        cfg_wr = WR && (ADDR == 3'h0 || ADDR == 3'h3);
  wire        pwm    = mode[0] && !mode[1] && quiet == 2'h3;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      mode <= 3'h0;
      per <= 8'h00;
      gap <= 8'h00;
      quiet <= 2'h0;
      seen <= 1'b0;
      rem <= 1'b0;
    end else begin
      mode <= (WR && ADDR == 3'h0) ? WDATA[2:0] : mode;
      per <= (WR && ADDR == 3'h1) ? WDATA : per;
      rem <= (WR && ADDR == 3'h3) ? WDATA[2] : rem;
      gap <= MATCH_IRQ ? 8'h00 : gap + 8'h01;
      quiet <= cfg_wr ? 2'h0 : quiet + {1'b0, quiet != 2'h3};
      seen <= !cfg_wr && (seen || MATCH_IRQ);
    end
  end
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  chk_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data not zero outside a read");
  chk_start_skip: assert property (WR && ADDR == 3'h0 && WDATA[2:0] == 3'h1 && mode == 3'h0
    && quiet == 2'h3 |-> (!TIMER_OUT && !MATCH_IRQ) [*4]) else $error("output during start skip");
  chk_stop_quiet: assert property (WR && ADDR == 3'h0 && WDATA[2:0] == 3'h0
    |-> ##3 (!MATCH_IRQ && !TIMER_OUT) [*4]) else $error("activity after stop");
  chk_irq_single: assert property (pwm && MATCH_IRQ |=> !MATCH_IRQ)
    else $error("match interrupt longer than one cycle");
  chk_rise_irq: assert property (pwm && $rose(TIMER_OUT ^ mode[2]) |-> MATCH_IRQ)
    else $error("active edge without period match");
  chk_fall_noirq: assert property (pwm && $fell(TIMER_OUT ^ mode[2]) |-> !MATCH_IRQ)
    else $error("interrupt on duty match");
  chk_pwm_period: assert property (pwm && seen && MATCH_IRQ |-> gap == per)
    else $error("period differs from setting");
  chk_carrier_edge: assert property (mode[1] && rem && quiet == 2'h3
    && !$stable(TIMER_OUT) |-> MATCH_IRQ) else $error("carrier edge without match");
  cover property (pwm && seen && MATCH_IRQ);
  cover property (mode[1] && rem && $rose(TIMER_OUT));
  cover property ($rose(COMPANION_IRQ));
endmodule : timer_h_pwm_carrier_gen_props
bind timer_h_pwm_carrier_gen timer_h_pwm_carrier_gen_props chk_u (.MCLK(MCLK), .RST(RST),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .COMPANION_IRQ(COMPANION_IRQ), .TIMER_OUT(TIMER_OUT), .MATCH_IRQ(MATCH_IRQ));
`default_nettype wire

//--- sim/timer_h_pwm_carrier_gen_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module timer_h_pwm_carrier_gen_tb_top;
  logic       mclk  = 1'b0;
  logic       rst   = 1'b1;
  logic [2:0] addr  = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic       start = 1'b0;
  logic [7:0] rdata;
  logic       c_irq;
  logic       t_out;
  logic       m_irq;
  logic [7:0] hi;
  logic [7:0] lo;
  int         err_total = 0;
  int         compares  = 0;
  always #25 mclk = ~mclk;
  timer_h_pwm_carrier_gen dut_u (.MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .COMPANION_IRQ(c_irq), .TIMER_OUT(t_out), .MATCH_IRQ(m_irq));
  companion_timer_model far_u (.mclk(mclk), .rst(rst), .start(start), .irq(c_irq));
  task automatic results();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    chk(rdata, exp);
  endtask : rd_reg
  task automatic wait_lvl(input logic v);
    int n;
    n = 0;
    while (t_out !== v) begin
      @(posedge mclk);
      n++;
      if (n > 600) begin
        err_total++;
        results();
      end
    end
  endtask : wait_lvl
  task automatic wave();
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    hi = 8'h00;
    lo = 8'h00;
    for (; t_out === 1'b1 && hi < 8'hFF; hi++) @(posedge mclk);
    for (; t_out === 1'b0 && lo < 8'hFF; lo++) @(posedge mclk);
  endtask : wave
  task automatic fire();
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
  endtask : fire
  task automatic t_reset();
    for (int a = 0; a < 8; a++) rd_reg(3'(a), 8'h00);
  endtask : t_reset
  task automatic t_pwm();
    wr_reg(3'h1, 8'h04);
    wr_reg(3'h2, 8'h01);
    wr_reg(3'h0, 8'h01);
    wave();
    chk(hi, 8'h02);
    chk(lo, 8'h03);
    wr_reg(3'h0, 8'h05);
    wave();
    wave();
    chk(hi, 8'h03);
    chk(lo, 8'h02);
    wr_reg(3'h0, 8'h00);
    repeat (4) @(posedge mclk);
    chk({6'h00, t_out, m_irq}, 8'h00);
  endtask : t_pwm
  task automatic t_duty();
    wr_reg(3'h1, 8'h08);
    wr_reg(3'h2, 8'h03);
    wr_reg(3'h0, 8'h01);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    wr_reg(3'h2, 8'h01);
    wave();
    chk(hi, 8'h04);
    wave();
    chk(hi, 8'h02);
    wr_reg(3'h0, 8'h00);
    repeat (8) @(posedge mclk);
  endtask : t_duty
  task automatic t_carrier();
    wr_reg(3'h1, 8'h02);
    wr_reg(3'h2, 8'h01);
    wr_reg(3'h3, 8'h06);
    wr_reg(3'h0, 8'h03);
    repeat (12) @(posedge mclk);
    chk({7'h00, t_out}, 8'h00);
    fire();
    repeat (3) @(posedge mclk);
    rd_reg(3'h3, 8'h06);
    rd_reg(3'h3, 8'h07);
    wave();
    chk(hi, 8'h02);
    chk(lo, 8'h03);
    wr_reg(3'h3, 8'h02);
    repeat (3) @(posedge mclk);
    chk({7'h00, t_out}, 8'h01);
    wr_reg(3'h3, 8'h00);
    fire();
    repeat (8) @(posedge mclk);
    chk({7'h00, t_out}, 8'h00);
    wr_reg(3'h0, 8'h00);
    repeat (8) @(posedge mclk);
    chk({7'h00, m_irq}, 8'h00);
  endtask : t_carrier
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_pwm();
    t_duty();
    t_carrier();
    results();
  end
endmodule : timer_h_pwm_carrier_gen_tb_top
`default_nettype wire
